// ===== design/serial_eeprom_write_protect.v
// Purpose : Slave write path of a 4 Kbit two-wire EEPROM with block protection
// Assumes : SCL and SDA are oversampled by sys_clk; read commands are acknowledged only
// Notes   : The array is flip-flops; a program cycle commits the latched bytes at its end
//
// Overview of operation
// - Select byte shifted MSB first on SCL rise
// - Upper nibble must equal device type
// - Chip-enable bits compared to two pins
// - Block bit picks one 256-byte half
// - RW bit one reads; ack on match
// - Byte address received and acknowledged
// - Mode pin high multibyte, low page
// - Write inhibit high leaves array unchanged
// - Byte write works in either mode
// - Multibyte: acknowledge every data byte
// - Multibyte program time doubles when rows differ
// - Up to eight bytes from any start address
// - Page write wraps low three bits
// - STOP starts program; device deaf meanwhile
// - Polling select unacknowledged until done
// - Protect from boundary through 1FFh
// - Pointer upper five bits give boundary
// - Protect pin low: 1FFh ordinary byte
`timescale 1ns/1ns
`include "serial_eeprom_map.vh"

module serial_eeprom_write_protect #(
   parameter        PROG_CYCLES = `PROG_CYCLES_DEF,  // Cycles for one program cycle
   parameter [3:0]  DEVICE_TYPE = 4'h5,              // Select identifier, value arbitrary
   parameter        SLOTS       = `ROW_BYTES         // Latched bytes per program cycle
) (
   input  wire       sys_clk,
   input  wire       reset,
   input  wire       scl,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe,
   input  wire       chip_select_bit_low,
   input  wire       chip_select_bit_high,
   input  wire       write_mode_multi,
   input  wire       write_inhibit_input,
   input  wire       protect_enable,
   input  wire [8:0] dbg_rd_addr,
   output reg  [7:0] dbg_rd_data,
   output wire       prog_busy,
   output wire [7:0] boundary_pointer
);

   // One-hot states
   localparam [5:0] ST_IDLE = 6'b00_0001;
   localparam [5:0] ST_SEL  = 6'b00_0010;
   localparam [5:0] ST_ADDR = 6'b00_0100;
   localparam [5:0] ST_DATA = 6'b00_1000;
   localparam [5:0] ST_ACK  = 6'b01_0000;
   localparam [5:0] ST_PROG = 6'b10_0000;

   localparam TW = 24;                                   // Program timer width
   localparam [TW-1:0] PROG_ONE = PROG_CYCLES[TW-1:0] - 24'h00_0001;
   localparam [TW-1:0] PROG_TWO = {PROG_CYCLES[TW-2:0], 1'b0} - 24'h00_0001;

   // Synchronised pins
   wire [6:0] pins_sync;                                 // Current sampled level
   wire [6:0] pins_prev;                                 // Level one cycle earlier
   wire       scl_s     = pins_sync[0];
   wire       scl_p     = pins_prev[0];
   wire       sda_s     = pins_sync[1];
   wire       sda_p     = pins_prev[1];
   wire       ce_low_s  = pins_sync[2];
   wire       ce_high_s = pins_sync[3];
   wire       multi_s   = pins_sync[4];
   wire       inhibit_s = pins_sync[5];
   wire       protect_s = pins_sync[6];

   // Bus events
   wire scl_rise = scl_s & ~scl_p;
   wire scl_fall = ~scl_s & scl_p;
   wire bus_start = scl_s & scl_p & sda_p & ~sda_s;
   wire bus_stop  = scl_s & scl_p & ~sda_p & sda_s;

   // Protocol state
   reg  [5:0]    state_q;                                // Current state
   reg  [5:0]    ret_q;                                  // State to enter after acknowledge
   reg  [7:0]    shift_q;                                // Incoming byte
   reg  [2:0]    bit_cnt_q;                              // Bits received in this byte
   reg           byte_full_q;                            // Eight bits received
   reg           ack_oe_q;                               // Pulling SDA low
   reg           block_q;                                // Selected 256-byte block
   reg  [7:0]    addr_q;                                 // Byte address within the block
   reg  [3:0]    nbytes_q;                               // Data bytes in this command
   reg  [5:0]    row_first_q;                            // Row of the first multibyte byte
   reg           span_q;                                 // Multibyte bytes on more than one row
   reg           inhibit_q;                              // Write inhibit seen this command
   reg  [TW-1:0] timer_q;                                // Program cycle countdown

   // Write latches
   reg  [7:0]    buf_data_q [0:SLOTS-1];                 // Latched data bytes
   reg  [8:0]    buf_addr_q [0:SLOTS-1];                 // Target address of each byte
   reg  [SLOTS-1:0] buf_valid_q;                         // Slot holds a byte

   // Array storage
   reg  [7:0]    mem_q [0:`ARRAY_DEPTH-1];

   wire       prog_done = (state_q == ST_PROG) && (timer_q == {TW{1'b0}});
   wire [7:0] ptr_byte  = mem_q[`PTR_ADDR];

   // Slot for the next data byte: row offset in page mode, count in multibyte mode
   wire [2:0] slot_idx   = multi_s ? nbytes_q[2:0] : addr_q[2:0];
   wire       slot_room  = multi_s ? (nbytes_q < 4'h8) : 1'b1;

   // True when an address sits inside the active protected region
   function is_protected;
      input [8:0] a;
      input [7:0] ptr;
      input       pin;
      begin
         is_protected = pin
                      & ~ptr[`PTR_FLAG_BIT]
                      & a[8]
                      & (a[7:3] >= ptr[`PTR_BOUND_MSB:`PTR_BOUND_LSB]);
      end
   endfunction

   // Does the select byte address this device
   function sel_match;
      input [7:0] b;
      input       ce_hi;
      input       ce_lo;
      begin
         sel_match = (b[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == DEVICE_TYPE)
                   & (b[`SEL_CE_HIGH_BIT] == ce_hi)
                   & (b[`SEL_CE_LOW_BIT] == ce_lo);
      end
   endfunction

   pin_sampler #(
      .WIDTH (7)
   ) u_pin_sampler (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .pins_raw  ({protect_enable, write_inhibit_input, write_mode_multi,
                   chip_select_bit_high, chip_select_bit_low, sda_in, scl}),
      .pins_sync (pins_sync),
      .pins_prev (pins_prev)
   );

   // Protocol engine: select, address, data, acknowledge, program
   always @(posedge sys_clk) begin
      if (reset) begin
         state_q     <= ST_IDLE;
         ret_q       <= ST_IDLE;
         shift_q     <= 8'h00;
         bit_cnt_q   <= 3'h0;
         byte_full_q <= 1'b0;
         ack_oe_q    <= 1'b0;
         block_q     <= 1'b0;
         addr_q      <= 8'h00;
         nbytes_q    <= 4'h0;
         row_first_q <= 6'h00;
         span_q      <= 1'b0;
         inhibit_q   <= 1'b0;
         timer_q     <= {TW{1'b0}};
         buf_valid_q <= {SLOTS{1'b0}};
      end else if (state_q == ST_PROG) begin
         // Deaf to the bus until the cycle ends; polling selects get no ack
         ack_oe_q <= 1'b0;
         if (prog_done) begin
            state_q     <= ST_IDLE;
            buf_valid_q <= {SLOTS{1'b0}};
         end else begin
            timer_q <= timer_q - 24'h00_0001;
         end
      end else if (bus_start) begin
         // Any START, repeated or not, begins a new select byte
         state_q     <= ST_SEL;
         bit_cnt_q   <= 3'h0;
         byte_full_q <= 1'b0;
         ack_oe_q    <= 1'b0;
      end else if (bus_stop) begin
         ack_oe_q    <= 1'b0;
         byte_full_q <= 1'b0;
         // STOP after at least one data byte starts the program cycle
         if (((state_q == ST_DATA) || (state_q == ST_ACK && ret_q == ST_DATA)) &&
             (nbytes_q != 4'h0)) begin
            state_q <= ST_PROG;
            timer_q <= span_q ? PROG_TWO : PROG_ONE;
         end else begin
            state_q     <= ST_IDLE;
            buf_valid_q <= {SLOTS{1'b0}};
         end
      end else begin
         case (state_q)
            ST_SEL, ST_ADDR, ST_DATA: begin
               // Shift in on the rising clock edge, most significant bit first
               if (scl_rise && !byte_full_q) begin
                  shift_q   <= {shift_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == 3'h7) begin
                     byte_full_q <= 1'b1;
                  end
               end
               // Falling edge after the eighth bit: decide the ninth bit
               if (scl_fall && byte_full_q) begin
                  byte_full_q <= 1'b0;
                  bit_cnt_q   <= 3'h0;
                  if (state_q == ST_SEL) begin
                     if (sel_match(shift_q, ce_high_s, ce_low_s)) begin
                        // Match: ack; read commands end after the ack
                        ack_oe_q <= 1'b1;
                        state_q  <= ST_ACK;
                        block_q  <= shift_q[`SEL_BLOCK_BIT];
                        ret_q    <= shift_q[`SEL_RW_BIT] ? ST_IDLE : ST_ADDR;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end else if (state_q == ST_ADDR) begin
                     // Byte address within the block, new command context
                     addr_q      <= shift_q;
                     nbytes_q    <= 4'h0;
                     span_q      <= 1'b0;
                     inhibit_q   <= 1'b0;
                     buf_valid_q <= {SLOTS{1'b0}};
                     ack_oe_q    <= 1'b1;
                     state_q     <= ST_ACK;
                     ret_q       <= ST_DATA;
                  end else begin
                     // Every data byte is acknowledged, stored or not
                     ack_oe_q <= 1'b1;
                     state_q  <= ST_ACK;
                     ret_q    <= ST_DATA;
                     if (inhibit_s) begin
                        inhibit_q <= 1'b1;
                     end
                     if (slot_room) begin
                        buf_data_q[slot_idx]  <= shift_q;
                        buf_addr_q[slot_idx]  <= {block_q, addr_q};
                        buf_valid_q[slot_idx] <= 1'b1;
                     end
                     if (nbytes_q == 4'h0) begin
                        row_first_q <= addr_q[`MULTI_ROW_MSB:`MULTI_ROW_LSB];
                     end else if (multi_s &&
                                  addr_q[`MULTI_ROW_MSB:`MULTI_ROW_LSB] != row_first_q) begin
                        span_q <= 1'b1;
                     end
                     if (nbytes_q != 4'hF) begin
                        nbytes_q <= nbytes_q + 4'h1;
                     end
                     // Mode pin is read at every byte and may change between bytes
                     if (multi_s) begin
                        addr_q <= addr_q + 8'h01;
                     end else begin
                        addr_q <= {addr_q[7:3], addr_q[2:0] + 3'h1};
                     end
                  end
               end
            end
            ST_ACK: begin
               // Release SDA when the ninth clock falls
               if (scl_fall) begin
                  ack_oe_q <= 1'b0;
                  state_q  <= ret_q;
               end
            end
            ST_IDLE: begin
               // Wait for a START
               ack_oe_q <= 1'b0;
            end
            default: begin
               state_q  <= ST_IDLE;
               ack_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // Array: erased at reset, latched bytes committed at the end of the program cycle
   integer j;
   always @(posedge sys_clk) begin
      if (reset) begin
         for (j = 0; j < `ARRAY_DEPTH; j = j + 1) begin
            mem_q[j] <= `ERASED_BYTE;
         end
      end else if (prog_done && !inhibit_q) begin
         for (j = 0; j < SLOTS; j = j + 1) begin
            if (buf_valid_q[j] && !is_protected(buf_addr_q[j], ptr_byte, protect_s)) begin
               mem_q[buf_addr_q[j]] <= buf_data_q[j];
            end
         end
      end
   end

   // Observation port for array contents
   always @(posedge sys_clk) begin
      if (reset) begin
         dbg_rd_data <= 8'h00;
      end else begin
         dbg_rd_data <= mem_q[dbg_rd_addr];
      end
   end

   // Open-drain SDA: only ever pulled low
   assign sda_out          = 1'b0;
   assign sda_oe           = ack_oe_q;
   assign prog_busy        = (state_q == ST_PROG);
   assign boundary_pointer = ptr_byte;

endmodule

// ===== design/serial_eeprom_map.vh
// Purpose : Constants shared by the serial EEPROM write logic
// Assumes : Included by bare name from the design files
// Notes   : Addresses are 9-bit array addresses, times are in microseconds
`ifndef SERIAL_EEPROM_MAP_VH
`define SERIAL_EEPROM_MAP_VH

// Array geometry
`define ARRAY_ADDR_W      9
`define ARRAY_DEPTH       32'h0000_0200
`define ERASED_BYTE       8'hFF

// Boundary pointer byte at the top of the array
`define PTR_ADDR          9'h1FF
`define PTR_FLAG_BIT      2
`define PTR_BOUND_MSB     7
`define PTR_BOUND_LSB     3

// Select byte layout, bit 7 is the first bit on the wire
`define SEL_TYPE_MSB      7
`define SEL_TYPE_LSB      4
`define SEL_CE_HIGH_BIT   3
`define SEL_CE_LOW_BIT    2
`define SEL_BLOCK_BIT     1
`define SEL_RW_BIT        0

// Row and write buffer sizes
`define ROW_BYTES         32'h0000_0008
`define MULTI_ROW_MSB     7
`define MULTI_ROW_LSB     2

// Program cycle timing
`define SYS_CLK_MHZ       32'h0000_00FA
`define PROG_TIME_US      32'h0000_2710
`define PROG_CYCLES_DEF   (`PROG_TIME_US * `SYS_CLK_MHZ)

`endif

// ===== design/pin_sampler.v
// Purpose : Two-stage synchroniser for a group of pins, plus one delayed copy
// Assumes : Pins are asynchronous to sys_clk
// Notes   : The first stage feeds only the second stage
`timescale 1ns/1ns

module pin_sampler #(
   parameter WIDTH = 7
) (
   input  wire             sys_clk,
   input  wire             reset,
   input  wire [WIDTH-1:0] pins_raw,
   output reg  [WIDTH-1:0] pins_sync,
   output reg  [WIDTH-1:0] pins_prev
);

   reg [WIDTH-1:0] meta_q;   // First stage, read only by the second

   // Two flip-flops, then a history stage for edge detection
   always @(posedge sys_clk) begin
      if (reset) begin
         meta_q    <= {WIDTH{1'b1}};
         pins_sync <= {WIDTH{1'b1}};
         pins_prev <= {WIDTH{1'b1}};
      end else begin
         meta_q    <= pins_raw;
         pins_sync <= meta_q;
         pins_prev <= pins_sync;
      end
   end

endmodule

// ===== testbench/serial_eeprom_write_protect_assertions.sv
// Purpose: Port checks of the EEPROM write block
// Assumes: One sys_clk domain, synchronous reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ns

module serial_eeprom_write_protect_assertions #(
   parameter PROG_CYCLES = 50
) (
   input wire       sys_clk,
   input wire       reset,
   input wire       scl,
   input wire       sda_in,
   input wire       sda_out,
   input wire       sda_oe,
   input wire [8:0] dbg_rd_addr,
   input wire [7:0] dbg_rd_data,
   input wire       prog_busy,
   input wire [7:0] boundary_pointer
);
   logic [31:0] busy_cnt_q; // Cycles of the running program cycle

   // Count busy cycles, clear when idle
   always @(posedge sys_clk) begin
      if (reset) busy_cnt_q <= 32'h0000_0000;
      else if (prog_busy) busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
      else busy_cnt_q <= 32'h0000_0000;
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   chk_drive_low:
   assert property (sda_out == 1'b0) else $error("data pin driven high");
   chk_ack_edge:
   assert property ($changed(sda_oe) |-> !scl && !$past(scl)) else $error("ack moved with clock high");
   chk_ack_hold:
   assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("ack too short");
   chk_busy_deaf:
   assert property (prog_busy |-> !sda_oe) else $error("ack while programming");
   chk_prog_start:
   assert property ($rose(prog_busy) |-> scl && sda_in && !$past(sda_in, 8)) else $error("program without stop");
   chk_prog_len:
   assert property ($fell(prog_busy) |-> busy_cnt_q == PROG_CYCLES || busy_cnt_q == 2 * PROG_CYCLES)
      else $error("program length wrong");
   chk_prog_bound:
   assert property (busy_cnt_q <= 2 * PROG_CYCLES) else $error("program too long");
   chk_ptr_commit:
   assert property ($changed(boundary_pointer) |-> prog_busy || $past(prog_busy)) else $error("pointer changed idle");
   chk_ptr_view:
   assert property (!$past(reset) && $past(dbg_rd_addr) == 9'h1FF |-> dbg_rd_data == $past(boundary_pointer))
      else $error("pointer differs from array");
endmodule

bind serial_eeprom_write_protect serial_eeprom_write_protect_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
   .sys_clk(sys_clk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .dbg_rd_addr(dbg_rd_addr), .dbg_rd_data(dbg_rd_data), .prog_busy(prog_busy),
   .boundary_pointer(boundary_pointer));

// ===== testbench/i2c_master_model.sv
// Purpose: Two-wire bus master model
// Assumes: Data line pulled up, released as 1
// Notes: Clock stands high between frames
`timescale 1ns/1ns

module i2c_master_model (
   output logic scl,
   output logic sda_drv,
   input  wire  sda_line
);
   logic ack;    // Ack seen in the ninth bit
   int   slow;   // Extra low time, slow master
   event ack_ev; // Ack result ready

   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      slow = 0;
   end

   // Data falls while clock is high
   task start;
      sda_drv <= 1'b1;
      #31 scl <= 1'b1;
      #31 sda_drv <= 1'b0;
      #31 scl <= 1'b0;
   endtask

   // Data changes only with clock low
   task bit_out(input logic b);
      #(31 + slow) sda_drv <= b;
      #31 scl <= 1'b1;
      #63 scl <= 1'b0;
   endtask

   // Byte MSB first, then release for ack
   task put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      #(31 + slow) sda_drv <= 1'b1;
      #31 scl <= 1'b1;
      #31 ack = !sda_line;
      -> ack_ev;
      #32 scl <= 1'b0;
   endtask

   // Data rises while clock is high
   task stop;
      #31 sda_drv <= 1'b0;
      #31 scl <= 1'b1;
      #31 sda_drv <= 1'b1;
      #31;
   endtask
endmodule

// ===== testbench/testbench.sv
// Purpose: Self-checking bench of the EEPROM write block
// Assumes: Bus master model on the link
// Notes: Expected array kept in em
`timescale 1ns/1ns

module testbench;
   localparam int         PC = 500;  // Short program time
   localparam logic [3:0] DT = 4'h5; // Device type, value arbitrary
   logic sys_clk, reset, cel, ceh, mode, inh, pe, rd_req, rd_seen_q;
   logic [8:0] rd_addr;
   wire scl, sda_drv, sda_oe, sda_out, busy;
   wire [7:0] rd_data, ptr;
   wire sda_in = sda_drv & ~(sda_oe & ~sda_out); // Wired-and line
   logic [7:0] em [0:511]; // Expected array
   logic [7:0] d [0:9];    // Sent data
   logic qa[$];            // Expected acks
   logic [7:0] qm[$];      // Expected reads
   logic [7:0] bad [4] = '{8'h80, 8'h10, 8'h08, 8'h04};
   int errors, compares, seed;

   serial_eeprom_write_protect #(.PROG_CYCLES(PC), .DEVICE_TYPE(DT)) i_serial_eeprom_write_protect (
      .sys_clk(sys_clk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .chip_select_bit_low(cel), .chip_select_bit_high(ceh), .write_mode_multi(mode),
      .write_inhibit_input(inh), .protect_enable(pe), .dbg_rd_addr(rd_addr), .dbg_rd_data(rd_data),
      .prog_busy(busy), .boundary_pointer(ptr));
   i2c_master_model i_master (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_in));

   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;

   task cmp_byte(input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task cmp_ack(input logic e, input logic g);
      cmp_byte({7'h00, e}, {7'h00, g});
   endtask

   // Oldest note against each result
   always @(i_master.ack_ev) cmp_ack(qa.pop_front(), i_master.ack);
   always @(posedge sys_clk) begin
      rd_seen_q <= rd_req;
      if (rd_seen_q) cmp_byte(qm.pop_front(), rd_data);
   end

   task summarize;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task xb(input logic [7:0] b, input logic e);
      qa.push_back(e);
      i_master.put_byte(b);
   endtask

   // Program cycle seen or not, then bounded wait for its end
   task wait_prog(input logic e);
      int n;
      n = 0;
      while (busy !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      cmp_ack(e, busy);
      n = 0;
      while (busy !== 1'b0 && n < 1200) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 1200) begin
         errors++;
         summarize;
      end
   endtask

   // Write command, one poll, expected commit
   task wr(input logic [8:0] a, input int n, input logic m, input int v);
      logic [8:0] x;
      logic [7:0] p;
      @(negedge sys_clk) mode = m;
      i_master.start;
      xb({DT, ceh, cel, a[8], 1'b0}, 1'b1);
      xb(a[7:0], 1'b1);
      for (int i = 0; i < n; i++) begin
         d[i] = (v < 0) ? 8'($random(seed)) : v[7:0];
         xb(d[i], 1'b1);
      end
      i_master.stop;
      p = em[511];
      for (int i = 0; i < n && (m == 1'b0 || i < 8); i++) begin
         x = m ? {a[8], a[7:0] + i[7:0]} : {a[8:3], a[2:0] + i[2:0]};
         if (!inh && !(pe && x[8] && x[7:3] >= p[7:3] && !p[2])) em[x] = d[i];
      end
      i_master.start;
      xb({DT, ceh, cel, 2'b00}, 1'b0);
      wait_prog(1'b1);
   endtask

   initial begin
      seed = 32'h9870cd22;
      errors = 0;
      compares = 0;
      reset = 1'b1;
      rd_req = 1'b0;
      rd_addr = 9'h000;
      {mode, inh, pe} = 3'h0;
      {ceh, cel} = 2'($random(seed));
      for (int k = 0; k < 512; k++) em[k] = 8'hFF;
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      repeat (4) @(negedge sys_clk);
      cmp_byte(8'hFF, ptr);
      wr(9'h012, 1, 1'b0, -1);
      wr(9'h013, 1, 1'b1, -1);
      for (int k = 0; k < 4; k++) begin
         i_master.start;
         xb({DT, ceh, cel, 2'b00} ^ bad[k], 1'b0);
         i_master.stop;
         wait_prog(1'b0);
      end
      i_master.start;
      xb({DT, ceh, cel, 2'b01}, 1'b1);
      i_master.stop;
      wait_prog(1'b0);
      wr(9'h10D, 9, 1'b0, -1);
      i_master.slow = 20;
      wr(9'h01E, 4, 1'b1, -1);
      i_master.slow = 0;
      wr(9'h040, 8, 1'b1, -1);
      inh = 1'b1;
      wr(9'h050, 2, 1'b1, -1);
      inh = 1'b0;
      pe = 1'b1;
      wr(9'h1F8, 2, 1'b0, -1);
      wr(9'h1FF, 1, 1'b0, 8'hF0);
      cmp_byte(8'hF0, ptr);
      wr(9'h1F0, 3, 1'b0, -1);
      wr(9'h1EE, 4, 1'b1, -1);
      pe = 1'b0;
      wr(9'h1F4, 2, 1'b0, -1);
      wr(9'h1FF, 1, 1'b0, 8'hF4);
      for (int k = 0; k < 512; k++) begin
         @(negedge sys_clk);
         rd_addr = k[8:0];
         qm.push_back(em[k]);
         rd_req = 1'b1;
         @(negedge sys_clk);
         rd_req = 1'b0;
      end
      repeat (4) @(negedge sys_clk);
      summarize;
   end
endmodule
